/* ccg_map.vh */
// register map, field positions, reset value and codes of the codec clock generation block
// assumes: included by bare name from the top, its assertions and the testbench
`ifndef CCG_MAP_VH
`define CCG_MAP_VH

// ---------------------------------------------------------------
// register placement (printed offset is an index, byte address = 4 x index)
// ---------------------------------------------------------------
`define CCG_ADDR_W        8
`define CCG_CTRL_INDEX    6'h06
`define CCG_CTRL_RESET    16'h0106

// ---------------------------------------------------------------
// field positions of clock_generation_control
// ---------------------------------------------------------------
`define CCG_OSC_BIT       15
`define CCG_PULL_HI       14
`define CCG_PULL_LO       13
`define CCG_CKO_SEL_BIT   12
`define CCG_CKO_DIV_HI    11
`define CCG_CKO_DIV_LO    10
`define CCG_CORE_EN_BIT   9
`define CCG_CORE_SRC_BIT  8
`define CCG_CORE_DIV_HI   7
`define CCG_CORE_DIV_LO   5
`define CCG_TO_EN_BIT     4
`define CCG_BCLK_DIV_HI   3
`define CCG_BCLK_DIV_LO   1
`define CCG_INTERFACE_MASTER_SELECT_BIT      0

// ---------------------------------------------------------------
// codes
// ---------------------------------------------------------------
`define CCG_PULL_DOWN     2'b01
`define CCG_PULL_UP       2'b10
`define CCG_BCLK_DIV_MAX  3'h5
`define CCG_SRC_STEP      5'h02
`define CCG_RESP_OKAY     2'b00
`define CCG_RESP_SLVERR   2'b10
`define CCG_TIMEOUT_DIV   16'h0028

`endif

/* ccg_tick_div.v */
// power-of-two divider of a tick stream: one output tick per 2**log2_div input ticks, at most 2**CNT_W
// assumes: tick_in is a one-cycle pulse on ref_clk; run low clears the count
`timescale 1ns/1ps
`default_nettype none

module ccg_tick_div #(
   parameter CODE_W = 3,
   parameter CNT_W  = 5
) (
   // clock and reset
   input  wire              ref_clk,
   input  wire              reset,
   // control
   input  wire              run,
   input  wire [CODE_W-1:0] log2_div,
   // ticks
   input  wire              tick_in,
   output reg               tick_out
);

   reg  [CNT_W-1:0] count;
   wire [CNT_W-1:0] one  = {{(CNT_W-1){1'b0}}, 1'b1};
   // wraps to all ones when the shift reaches the counter width
   wire [CNT_W-1:0] last = (one << log2_div) - one;

   always @(posedge ref_clk) begin
      if (reset || !run) begin
         count    <= {CNT_W{1'b0}};
         tick_out <= 1'b0;
      end else if (tick_in) begin
         if (count == last) begin
            count    <= {CNT_W{1'b0}};
            tick_out <= 1'b1;
         end else begin
            count    <= count + one;
            tick_out <= 1'b0;
         end
      end else begin
         tick_out <= 1'b0;
      end
   end

endmodule // ccg_tick_div
`default_nettype wire

/* ccg_top.v */
// codec clock generation: core clock source/divider/gate, clock output pin, bit clock, timeout clock
// assumes: ref_clk is the reference clock input and the root clock; loop output and host bit clock
// arrive asynchronously and are sampled; clocks leave as one-cycle ticks on ref_clk, except bclk_out, which toggles on each master bit clock tick
`timescale 1ns/1ps
`default_nettype none
`include "ccg_map.vh"

module ccg_top #(
   parameter TIMEOUT_DIV = `CCG_TIMEOUT_DIV
) (
   // clock and reset
   input  wire                 ref_clk,
   input  wire                 reset,
   // axi4-lite write address
   input  wire [`CCG_ADDR_W-1:0] s_axi_awaddr,
   input  wire                 s_axi_awvalid,
   output reg                  s_axi_awready,
   // axi4-lite write data
   input  wire [31:0]          s_axi_wdata,
   input  wire [3:0]           s_axi_wstrb,
   input  wire                 s_axi_wvalid,
   output reg                  s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]           s_axi_bresp,
   output reg                  s_axi_bvalid,
   input  wire                 s_axi_bready,
   // axi4-lite read
   input  wire [`CCG_ADDR_W-1:0] s_axi_araddr,
   input  wire                 s_axi_arvalid,
   output reg                  s_axi_arready,
   output reg  [31:0]          s_axi_rdata,
   output reg  [1:0]           s_axi_rresp,
   output reg                  s_axi_rvalid,
   input  wire                 s_axi_rready,
   // clock sources and pins
   input  wire                 freq_locked_loop,
   input  wire                 bclk_in,
   output reg                  bclk_out,
   output reg                  bclk_oe,
   output wire                 clock_output_pin,
   output reg                  ref_pull_down,
   output reg                  ref_pull_up,
   // clocks to the rest of the codec
   output reg                  core_clock,
   output reg                  bit_clock_tick,
   output reg                  timeout_clock,
   output reg                  internal_osc_enable
);

   // ---------------------------------------------------------------
   // register file and bus slave
   // ---------------------------------------------------------------
   reg  [15:0]             clock_generation_control;
   reg  [`CCG_ADDR_W-1:0]  aw_addr;
   reg                     aw_held;
   reg  [31:0]             w_data;
   reg  [3:0]              w_strb;
   reg                     w_held;
   wire [`CCG_ADDR_W-1:0]  ctrl_addr = {`CCG_CTRL_INDEX, 2'b00};
   wire                    do_write  = aw_held && w_held && !s_axi_bvalid;

   always @(posedge ref_clk) begin
      if (reset) begin
         s_axi_awready            <= 1'b1;
         s_axi_wready             <= 1'b1;
         aw_held                  <= 1'b0;
         w_held                   <= 1'b0;
         aw_addr                  <= {`CCG_ADDR_W{1'b0}};
         w_data                   <= 32'h0;
         w_strb                   <= 4'h0;
         s_axi_bvalid             <= 1'b0;
         s_axi_bresp              <= `CCG_RESP_OKAY;
         clock_generation_control <= `CCG_CTRL_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr       <= s_axi_awaddr;
            aw_held       <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            w_held       <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == ctrl_addr) ? `CCG_RESP_OKAY : `CCG_RESP_SLVERR;
            if (aw_addr == ctrl_addr && w_strb[0])
               clock_generation_control[7:0] <= w_data[7:0];
            if (aw_addr == ctrl_addr && w_strb[1])
               clock_generation_control[15:8] <= w_data[15:8];
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `CCG_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata <= (s_axi_araddr == ctrl_addr) ? {16'h0, clock_generation_control} : 32'h0;
         s_axi_rresp <= (s_axi_araddr == ctrl_addr) ? `CCG_RESP_OKAY : `CCG_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   wire       osc_en     = clock_generation_control[`CCG_OSC_BIT];
   wire [1:0] pull_code  = clock_generation_control[`CCG_PULL_HI:`CCG_PULL_LO];
   wire       cko_sel    = clock_generation_control[`CCG_CKO_SEL_BIT];
   wire [1:0] cko_div    = clock_generation_control[`CCG_CKO_DIV_HI:`CCG_CKO_DIV_LO];
   wire       core_en    = clock_generation_control[`CCG_CORE_EN_BIT];
   wire       core_src   = clock_generation_control[`CCG_CORE_SRC_BIT];
   wire [2:0] core_div   = clock_generation_control[`CCG_CORE_DIV_HI:`CCG_CORE_DIV_LO];
   wire       to_en      = clock_generation_control[`CCG_TO_EN_BIT];
   wire [2:0] bclk_div   = clock_generation_control[`CCG_BCLK_DIV_HI:`CCG_BCLK_DIV_LO];
   wire       master     = clock_generation_control[`CCG_INTERFACE_MASTER_SELECT_BIT];

   // ---------------------------------------------------------------
   // pad controls
   // ---------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (reset) begin
         ref_pull_down       <= 1'b0;
         ref_pull_up         <= 1'b0;
         internal_osc_enable <= 1'b0;
         bclk_oe             <= 1'b0;
      end else begin
         // reserved code leaves the pad unbiased
         ref_pull_down       <= (pull_code == `CCG_PULL_DOWN);
         ref_pull_up         <= (pull_code == `CCG_PULL_UP);
         internal_osc_enable <= osc_en;
         // drive bit clock pin only as master
         bclk_oe             <= master;
      end
   end

   // ---------------------------------------------------------------
   // input synchronisers and edge detect
   // ---------------------------------------------------------------
   reg [2:0] fll_sync;
   reg [2:0] bclk_sync;

   always @(posedge ref_clk) begin
      if (reset) begin
         fll_sync  <= 3'h0;
         bclk_sync <= 3'h0;
      end else begin
         fll_sync  <= {fll_sync[1:0], freq_locked_loop};
         bclk_sync <= {bclk_sync[1:0], bclk_in};
      end
   end

   wire fll_tick  = fll_sync[1] && !fll_sync[2];
   wire host_bclk = bclk_sync[1] && !bclk_sync[2];

   // ---------------------------------------------------------------
   // core clock: source select and fractional divider
   // ---------------------------------------------------------------
   // twice the division ratio, so the 1.5 and odd steps stay integer
   function [4:0] half_ratio;
      input [2:0] code;
      begin
         case (code)
            3'h0:    half_ratio = 5'h02;
            3'h1:    half_ratio = 5'h03;
            3'h2:    half_ratio = 5'h04;
            3'h3:    half_ratio = 5'h06;
            3'h4:    half_ratio = 5'h08;
            3'h5:    half_ratio = 5'h0c;
            3'h6:    half_ratio = 5'h10;
            default: half_ratio = 5'h18;
         endcase
      end
   endfunction

   // reference input ticks every cycle, loop output on its rising edges
   wire       src_tick  = core_src ? fll_tick : 1'b1;
   reg  [4:0] core_acc;
   reg        core_raw;
   reg        src_tick_q;
   wire [4:0] core_sum  = core_acc + `CCG_SRC_STEP;
   wire [4:0] core_lim  = half_ratio(core_div);

   always @(posedge ref_clk) begin
      if (reset) begin
         core_acc   <= 5'h00;
         core_raw   <= 1'b0;
         core_clock <= 1'b0;
         src_tick_q <= 1'b0;
      end else begin
         src_tick_q <= src_tick;  // lines up with core_raw for the pin
         // ratio set by the divider code
         if (src_tick) begin
            if (core_sum >= core_lim) begin
               core_acc <= core_sum - core_lim;
               core_raw <= 1'b1;
            end else begin
               core_acc <= core_sum;
               core_raw <= 1'b0;
            end
         end else begin
            core_raw <= 1'b0;
         end
         core_clock <= core_raw && core_en;
      end
   end

   // ---------------------------------------------------------------
   // clock output pin
   // ---------------------------------------------------------------
   // divided core clock before the core_en gate, or undivided source, then /1 /2 /4 /8
   ccg_tick_div #(.CODE_W(2), .CNT_W(3)) u_cko_div (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .run      (1'b1),
      .log2_div (cko_div),
      .tick_in  (cko_sel ? src_tick_q : core_raw),
      .tick_out (clock_output_pin)
   );

   // ---------------------------------------------------------------
   // bit clock
   // ---------------------------------------------------------------
   wire mst_bclk;
   ccg_tick_div #(.CODE_W(3), .CNT_W(5)) u_bclk_div (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .run      (master && (bclk_div <= `CCG_BCLK_DIV_MAX)),
      .log2_div (bclk_div),
      .tick_in  (core_raw),
      .tick_out (mst_bclk)
   );

   always @(posedge ref_clk) begin
      if (reset) begin
         bit_clock_tick <= 1'b0;
         bclk_out       <= 1'b0;
      end else begin
         // slave follows the host's bit clock
         bit_clock_tick <= master ? mst_bclk : host_bclk;
         bclk_out       <= bclk_out ^ (master && mst_bclk);
      end
   end

   // ---------------------------------------------------------------
   // timeout clock
   // ---------------------------------------------------------------
   reg [15:0] to_count;

   always @(posedge ref_clk) begin
      // runs only while enabled, and only with the oscillator on
      if (reset || !(to_en && osc_en)) begin
         to_count      <= 16'h0;
         timeout_clock <= 1'b0;
      end else begin
         if (to_count == TIMEOUT_DIV[15:0] - 16'h1) begin
            to_count      <= 16'h0;
            timeout_clock <= 1'b1;
         end else begin
            to_count      <= to_count + 16'h1;
            timeout_clock <= 1'b0;
         end
      end
   end

endmodule // ccg_top
`default_nettype wire

/* ccg_top_assertions.sv */
// port assertions and covers for the codec clock generation top
// assumes: bound into ccg_top, one ref_clk domain, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "ccg_map.vh"
module ccg_top_chk #(
   parameter TIMEOUT_DIV = `CCG_TIMEOUT_DIV
) (
   // clock and reset
   input wire logic                   ref_clk,
   input wire logic                   reset,
   // register bus
   input wire logic                   s_axi_awvalid,
   input wire logic                   s_axi_awready,
   input wire logic                   s_axi_wvalid,
   input wire logic                   s_axi_wready,
   input wire logic [1:0]             s_axi_bresp,
   input wire logic                   s_axi_bvalid,
   input wire logic                   s_axi_bready,
   input wire logic [`CCG_ADDR_W-1:0] s_axi_araddr,
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic [31:0]            s_axi_rdata,
   input wire logic [1:0]             s_axi_rresp,
   input wire logic                   s_axi_rvalid,
   input wire logic                   s_axi_rready,
   // clock side
   input wire logic                   bclk_oe,
   input wire logic                   clock_output_pin,
   input wire logic                   ref_pull_down,
   input wire logic                   ref_pull_up,
   input wire logic                   core_clock,
   input wire logic                   timeout_clock,
   input wire logic                   internal_osc_enable
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   a_pull_excl: assert property (!(ref_pull_down && ref_pull_up))
      else $error("both pad biases on");
   a_reset_quiet: assert property ($fell(reset) |->
      !internal_osc_enable && !bclk_oe && !core_clock && !timeout_clock) else $error("outputs active after reset");
   // osc output lags its bit, so allow the pipeline to drain
   a_timeout_gated: assert property (!internal_osc_enable [*3] |-> !timeout_clock)
      else $error("timeout tick without oscillator");
   a_rd_mapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h18 |=>
      s_axi_rvalid && s_axi_rresp == `CCG_RESP_OKAY && s_axi_rdata[31:16] == 16'h0) else $error("bad register read");
   a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr != 8'h18 |=>
      s_axi_rvalid && s_axi_rresp == `CCG_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
   a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_ar_refuse: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
      else $error("second read taken");
   a_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
      !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response timing");
   a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `CCG_RESP_SLVERR);
   c_timeout: cover property (timeout_clock);
   c_master_out: cover property (bclk_oe && clock_output_pin);
endmodule // ccg_top_chk
bind ccg_top ccg_top_chk #(.TIMEOUT_DIV(TIMEOUT_DIV)) chk_u (.*);
`default_nettype wire

/* ccg_far_model.sv */
// far side: free-running loop output and serial audio host bit clock
// assumes: periods unrelated to ref_clk; the design samples both
`timescale 1ns/1ps
`default_nettype none
module ccg_far_model (
   // pin state
   input  wire logic bclk_oe,
   // clocks
   output var logic  freq_locked_loop,
   output var logic  host_bclk
);
   initial freq_locked_loop = 1'b0;
   initial host_bclk = 1'b0;
   always #51.3 freq_locked_loop = ~freq_locked_loop;
   // host drives bit clock only in slave mode
   always #77.1 if (!bclk_oe) host_bclk = ~host_bclk;
endmodule // ccg_far_model
`default_nettype wire

/* testbench.sv */
// self-checking bench: axi4-lite register tasks and tick counting
// assumes: ccg_top with one-cycle tick outputs on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "ccg_map.vh"
module testbench;
   localparam int to_div = 4;
   localparam logic [7:0] reg_addr = 8'h18;
   // stimulus
   logic        ref_clk = 1'b0, reset = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   // design outputs
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire         freq_locked_loop, host_bclk, bclk_out, bclk_oe, clock_output_pin;
   wire         ref_pull_down, ref_pull_up, core_clock, bit_clock_tick, timeout_clock, internal_osc_enable;
   wire         bclk_line = bclk_oe ? bclk_out : host_bclk;
   logic        bclk_q = 1'b0;
   wire  [4:0]  ticks = {bclk_out ^ bclk_q, timeout_clock, bit_clock_tick, clock_output_pin, core_clock};
   int          n_mismatch = 0, checks_done = 0, k;
   int          r2 [8] = '{2, 3, 4, 6, 8, 12, 16, 24};
   logic [31:0] d;
   logic [1:0]  r;

   always #12.5 ref_clk = ~ref_clk;
   // previous pin level, so ticks[4] marks each toggle of the bit clock pin
   always @(posedge ref_clk) bclk_q <= bclk_out;
   ccg_top #(.TIMEOUT_DIV(to_div)) dut_u (.*, .bclk_in(bclk_line));
   ccg_far_model far_u (.bclk_oe(bclk_oe), .freq_locked_loop(freq_locked_loop), .host_bclk(host_bclk));

   task automatic check(input logic ok, input string what);
      checks_done++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("Error at %0t: %s", $time, what);
      end
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      int t;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (t = 0; t < 50; t++) begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      check(t < 50, "write hang");
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      int t;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (t = 0; t < 50; t++) begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      v = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      check(t < 50, "read hang");
   endtask

   // counts one tick output over 240 cycles after the controls settle
   task automatic measure(input int sel, input int exp, input int tol, input string what);
      int c;
      c = 0;
      repeat (8) @(posedge ref_clk);
      repeat (240) begin
         @(posedge ref_clk);
         c += (ticks[sel] === 1'b1);
      end
      check(c >= exp - tol && c <= exp + tol, what);
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      axi_read(reg_addr, d, r);
      check(d === {16'h0, `CCG_CTRL_RESET} && r === `CCG_RESP_OKAY, "reset value");
      check(bclk_oe === 1'b0 && internal_osc_enable === 1'b0, "reset pins");
      axi_read(8'h1c, d, r);
      check(d === 32'h0 && r === `CCG_RESP_SLVERR, "unmapped read");
      axi_write(8'h1c, 32'hffff, r);
      check(r === `CCG_RESP_SLVERR, "unmapped write response");
      axi_read(reg_addr, d, r);
      check(r === `CCG_RESP_OKAY && d === {16'h0, `CCG_CTRL_RESET}, "unmapped write");
      s_axi_wstrb <= 4'h2;
      axi_write(reg_addr, 32'h0000ffff, r);
      s_axi_wstrb <= 4'hf;
      axi_read(reg_addr, d, r);
      check(d === 32'h0000ff06, "byte strobe");
      $display("test registers done");
      for (k = 0; k < 4; k++) begin
         axi_write(reg_addr, k << 13, r);
         axi_read(reg_addr, d, r);
         check(d === k << 13, "bias readback");
         check({ref_pull_up, ref_pull_down} === ((k == 3) ? 2'b00 : k[1:0]), "bias pads");
      end
      axi_write(reg_addr, 32'h8010, r);
      // pad outputs follow the register one edge after the response
      @(posedge ref_clk);
      check(internal_osc_enable === 1'b1, "osc enable");
      measure(3, 240 / to_div, 1, "timeout rate");
      axi_write(reg_addr, 32'h0010, r);
      measure(3, 0, 0, "timeout without osc");
      axi_write(reg_addr, 32'h8000, r);
      measure(3, 0, 0, "timeout disabled");
      $display("test osc and timeout done");
      for (k = 0; k < 8; k++) begin
         axi_write(reg_addr, 32'h200 | (k << 5), r);
         measure(0, 480 / r2[k], 1, "core divider");
      end
      axi_write(reg_addr, 32'h0, r);
      measure(0, 0, 0, "core gated");
      axi_write(reg_addr, 32'h300, r);
      measure(0, 58, 3, "loop source");
      $display("test core clock done");
      for (k = 0; k < 4; k++) begin
         axi_write(reg_addr, 32'h200 | (k << 10), r);
         measure(1, 240 >> k, 1, "clock out core");
         axi_write(reg_addr, 32'h10e0 | (k << 10), r);
         measure(1, 240 >> k, 1, "clock out source");
      end
      $display("test clock output done");
      for (k = 0; k < 8; k++) begin
         axi_write(reg_addr, 32'h1 | (k << 1), r);
         @(posedge ref_clk);
         check(bclk_oe === 1'b1, "master drives");
         measure(2, (k < 6) ? (240 >> k) : 0, 1, "bit clock divider");
         measure(4, (k < 6) ? (240 >> k) : 0, 1, "bit clock pin");
      end
      axi_write(reg_addr, 32'h0, r);
      @(posedge ref_clk);
      check(bclk_oe === 1'b0, "slave releases");
      // host half period 77.1 ns: about 39 rising edges in 240 cycles
      measure(2, 39, 2, "host bit clock");
      $display("test bit clock done");
      axi_write(reg_addr, 32'h8201, r);
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      axi_read(reg_addr, d, r);
      check(d === {16'h0, `CCG_CTRL_RESET} && bclk_oe === 1'b0, "second reset");
      $display("test second reset done");
      print_verdict;
   end

   initial begin
      #1000000;
      n_mismatch++;
      print_verdict;
   end
endmodule // testbench
`default_nettype wire
